// ===== aipb_pkg.sv
/*
 * aipb_pkg: shared constants of the arcade input port bank.
 * Assumes a 16-bit data path and byte addresses as seen by the CPU bus.
 */
package aipb_pkg;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_MISC_STATUS_INPUTS   = 32'h1f400006;
    localparam logic [31:0] ADDR_PLAYER_CONTROLS      = 32'h1f400008;
    localparam logic [31:0] ADDR_LINK_DATA_WORD       = 32'h1f40000a;
    localparam logic [31:0] ADDR_PLAYER1_EXTRA_INPUTS = 32'h1f40000c;
    localparam logic [31:0] ADDR_PLAYER2_EXTRA_INPUTS = 32'h1f40000e;
    localparam logic [31:0] ADDR_LINK_READY_CLEAR     = 32'h1f520000;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MISC_IO_LINE0_BIT    = 2;
    localparam int MISC_LINK_READY_BIT  = 4;
    localparam int EXTRA_BTN4_BIT       = 8;
    localparam int EXTRA_BTN5_BIT       = 9;
    localparam int EXTRA_TEST_BIT       = 10;
    localparam int EXTRA_RAM_LAYOUT_BIT = 10;
    localparam int EXTRA_BTN6_BIT       = 11;
    localparam int PLAYER1_BASE_BIT     = 8;

    // ------------------------------------------------------------
    // widths, reset and fill values
    // ------------------------------------------------------------
    localparam int          DATA_WIDTH        = 16;
    localparam int          LINK_FIFO_DEPTH   = 4;
    localparam logic [15:0] UNUSED_FILL       = 16'h0000;
    localparam logic [15:0] UNMAPPED_READ     = 16'h0000;
    localparam logic [15:0] LINK_WORD_RESET   = 16'h0000;
    localparam logic        LINK_READY_RESET  = 1'b0;
    localparam logic [15:0] RD_DATA_RESET     = 16'h0000;
    localparam logic [63:0] PIN_IDLE_RESET    = 64'hffffffffffffffff;

endpackage

// ===== aipb_stream_if.sv
/*
 * aipb_stream_if: valid/ready word stream between the link FIFO and the
 * data port logic. Both ends run on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none

interface aipb_stream_if #(
    parameter int WIDTH = 16
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    // source drives the word, sink accepts it
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// ===== aipb_sync.sv
/*
 * aipb_sync: two-flop synchroniser for a vector of pin levels.
 * Assumes each bit is an independent level; no bus coherency is given.
 */
`timescale 1ns/1ps
`default_nettype none

module aipb_sync #(
    parameter int          WIDTH     = 1,
    parameter logic [63:0] RESET_VAL = 64'hffffffffffffffff
) (
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_ff;

    initial begin
        if (WIDTH < 1 || WIDTH > 64) $error("aipb_sync: WIDTH out of range");
    end

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            stage1_ff <= RESET_VAL[WIDTH-1:0];
            syncOut   <= RESET_VAL[WIDTH-1:0];
        end else begin
            stage1_ff <= pinIn;
            syncOut   <= stage1_ff;
        end
    end
endmodule

`default_nettype wire

// ===== aipb_fifo.sv
/*
 * aipb_fifo: small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; ready (full) is a registered flag, valid (empty) is decoded from the registered count.
 */
`timescale 1ns/1ps
`default_nettype none

module aipb_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    aipb_stream_if.src            out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_ff;
    logic [AW-1:0]    rdPtr_ff;
    logic [AW:0]      count_ff;
    logic             push;
    logic             pop;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("aipb_fifo: DEPTH must be a power of two >= 2");
        if (WIDTH < 1) $error("aipb_fifo: WIDTH must be positive");
    end

    // handshakes on both sides
    assign push      = inValid && inReady;
    assign pop       = out.valid && out.ready;
    assign out.valid = (count_ff != '0);
    assign out.data  = mem[rdPtr_ff];

    // storage; no reset needed, guarded by count
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wrPtr_ff] <= inData;
        end
    end

    // pointers, fill level and registered ready
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
            inReady  <= 1'b0;
        end else begin
            if (push) wrPtr_ff <= wrPtr_ff + AW'(1);
            if (pop)  rdPtr_ff <= rdPtr_ff + AW'(1);
            case ({push, pop})
                2'b10: begin
                    count_ff <= count_ff + (AW+1)'(1);
                    inReady  <= (count_ff != (AW+1)'(DEPTH - 1));
                end
                2'b01: begin
                    count_ff <= count_ff - (AW+1)'(1);
                    inReady  <= 1'b1;
                end
                default: begin
                    inReady <= (count_ff != (AW+1)'(DEPTH));
                end
            endcase
        end
    end
endmodule

`default_nettype wire

// ===== aipb_input_port_bank.sv
/*
 * aipb_input_port_bank: read-only input ports of the arcade I/O chip,
 * plus the link data port fed by the serial-link microcontroller.
 * Assumes the CPU bus is synchronous to ref_clk with one-cycle strobes,
 * and that the microcontroller side (linkWordValid/linkWord) is logic on
 * ref_clk; button, strap and misc lines are asynchronous pins.
 */
`timescale 1ns/1ps
`default_nettype none

// Function
// [RULE_01] software sets io line 0 input first
// [RULE_02] player controls: p2 low byte, p1 high
// [RULE_03] buttons active low: pressed reads zero
// [RULE_04] player controls read has no side effects
// [RULE_05] link data valid only while ready set
// [RULE_06] any write to clear address drops ready
// [RULE_07] pending word reloads port, sets ready again
// [RULE_08] p1 extras: btn4, btn5, test, btn6
// [RULE_09] p2 extras: btn4, btn5, btn6 on 8,9,11
// [RULE_10] bit 10 reports ram layout strap
// [RULE_11] boot software chooses ram config from strap
// [RULE_12] link ready visible on misc bit 4
// [RULE_13] writes ignored, unused bits read constant
module aipb_input_port_bank #(
    parameter int LINK_FIFO_DEPTH = aipb_pkg::LINK_FIFO_DEPTH
) (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // cpu bus
    input  wire logic        busCs,
    input  wire logic        busRd,
    input  wire logic        busWr,
    input  wire logic [31:0] busAddr,
    input  wire logic [15:0] busWrData,
    output logic      [15:0] busRdData,
    output logic             busRdValid,
    // control pins; buttons active low, strap and misc lines taken as driven
    input  wire logic [15:0] playerCtrlPins_n,
    input  wire logic [3:0]  p1ExtraPins_n,
    input  wire logic [2:0]  p2ExtraPins_n,
    input  wire logic        ramLayoutOld,
    input  wire logic [15:0] miscRawPins,
    // serial-link microcontroller words
    input  wire logic        linkWordValid,
    input  wire logic [15:0] linkWord,
    output logic             linkWordReady,
    output logic             linkInputReady
);
    localparam int W = aipb_pkg::DATA_WIDTH;

    initial begin
        if (W != 16) $error("aipb_input_port_bank: data width must be 16");
        if (LINK_FIFO_DEPTH < 2) $error("aipb_input_port_bank: fifo depth too small");
        if (aipb_pkg::MISC_LINK_READY_BIT >= W) $error("aipb_input_port_bank: flag bit outside port");
        if (aipb_pkg::EXTRA_BTN6_BIT >= W) $error("aipb_input_port_bank: extras bit outside port");
    end

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [31:0] a, input logic [31:0] ref_a);
        hit = (a == ref_a);
    endfunction

    // port codes of the decoder; the clear address reads like an unmapped one
    localparam logic [2:0] SEL_MISC   = 3'h0;
    localparam logic [2:0] SEL_PLAYER = 3'h1;
    localparam logic [2:0] SEL_LINK   = 3'h2;
    localparam logic [2:0] SEL_P1X    = 3'h3;
    localparam logic [2:0] SEL_P2X    = 3'h4;
    localparam logic [2:0] SEL_CLEAR  = 3'h5;
    localparam logic [2:0] SEL_NONE   = 3'h7;

    // one decoder for reads and the clear write, so both see the same map
    function automatic logic [2:0] port_of(input logic [31:0] a);
        if (hit(a, aipb_pkg::ADDR_MISC_STATUS_INPUTS)) begin
            port_of = SEL_MISC;
        end else if (hit(a, aipb_pkg::ADDR_PLAYER_CONTROLS)) begin
            port_of = SEL_PLAYER;
        end else if (hit(a, aipb_pkg::ADDR_LINK_DATA_WORD)) begin
            port_of = SEL_LINK;
        end else if (hit(a, aipb_pkg::ADDR_PLAYER1_EXTRA_INPUTS)) begin
            port_of = SEL_P1X;
        end else if (hit(a, aipb_pkg::ADDR_PLAYER2_EXTRA_INPUTS)) begin
            port_of = SEL_P2X;
        end else if (hit(a, aipb_pkg::ADDR_LINK_READY_CLEAR)) begin
            port_of = SEL_CLEAR;
        end else begin
            port_of = SEL_NONE;
        end
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [15:0] playerCtrlSync;
    logic [3:0]  p1ExtraSync;
    logic [2:0]  p2ExtraSync;
    logic        ramLayoutSync;
    logic [15:0] miscSync;

    // player controls; released buttons idle high, so reset to ones
    aipb_sync #(
        .WIDTH     (16),
        .RESET_VAL (aipb_pkg::PIN_IDLE_RESET)
    ) u_syncPlayer (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .pinIn   (playerCtrlPins_n),
        .syncOut (playerCtrlSync)
    );

    // player 1 extras, same idle level as the main buttons
    aipb_sync #(
        .WIDTH     (4),
        .RESET_VAL (aipb_pkg::PIN_IDLE_RESET)
    ) u_syncP1Extra (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .pinIn   (p1ExtraPins_n),
        .syncOut (p1ExtraSync)
    );

    // player 2 extras
    aipb_sync #(
        .WIDTH     (3),
        .RESET_VAL (aipb_pkg::PIN_IDLE_RESET)
    ) u_syncP2Extra (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .pinIn   (p2ExtraPins_n),
        .syncOut (p2ExtraSync)
    );

    // strap on its own pair: a static level, not a button, so its
    // reset level can change later without touching the buttons
    aipb_sync #(
        .WIDTH     (1),
        .RESET_VAL (aipb_pkg::PIN_IDLE_RESET)
    ) u_syncStrap (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .pinIn   (ramLayoutOld),
        .syncOut (ramLayoutSync)
    );

    // misc lines; bit 4 is overwritten by the link flag further down
    aipb_sync #(
        .WIDTH     (16),
        .RESET_VAL (aipb_pkg::PIN_IDLE_RESET)
    ) u_syncMisc (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .pinIn   (miscRawPins),
        .syncOut (miscSync)
    );

    // ------------------------------------------------------------
    // link word buffer
    // ------------------------------------------------------------
    aipb_stream_if #(.WIDTH(W)) linkStream ();

    // back-pressure reaches the microcontroller through linkWordReady
    aipb_fifo #(
        .WIDTH (W),
        .DEPTH (LINK_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .inValid (linkWordValid),
        .inData  (linkWord),
        .inReady (linkWordReady),
        .out     (linkStream)
    );

    // ------------------------------------------------------------
    // bus strobes
    // ------------------------------------------------------------
    logic rdStrobe;
    logic wrStrobe;
    logic readyClearHit;

    assign rdStrobe      = busCs && busRd;
    assign wrStrobe      = busCs && busWr;
    assign readyClearHit = wrStrobe && (port_of(busAddr) == SEL_CLEAR); // RULE_06

    // ------------------------------------------------------------
    // link data port and ready flag
    // ------------------------------------------------------------
    logic [15:0] linkData_ff;
    logic        linkReady_ff;
    logic        loadWord;

    // a word is taken whenever the port is free or is being freed this cycle,
    // so a clear with a word pending ends with the flag still set
    assign loadWord         = linkStream.valid && (!linkReady_ff || readyClearHit); // RULE_07
    assign linkStream.ready = !linkReady_ff || readyClearHit;

    // data port holds the word until the next load; reads never touch it
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            linkData_ff <= aipb_pkg::LINK_WORD_RESET;
        end else if (loadWord) begin
            linkData_ff <= linkStream.data; // RULE_05
        end
    end

    // set wins over clear
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            linkReady_ff <= aipb_pkg::LINK_READY_RESET;
        end else if (loadWord) begin
            linkReady_ff <= 1'b1; // RULE_07
        end else if (readyClearHit) begin
            linkReady_ff <= 1'b0; // RULE_06
        end
    end

    // mirror of the flag for the board
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            linkInputReady <= aipb_pkg::LINK_READY_RESET;
        end else begin
            linkInputReady <= linkReady_ff;
        end
    end

    // ------------------------------------------------------------
    // port images
    // ------------------------------------------------------------
    logic [15:0] miscImage;
    logic [15:0] playerImage;
    logic [15:0] p1ExtraImage;
    logic [15:0] p2ExtraImage;

    // misc: raw lines, link flag forced onto its bit; io line 0 is only
    // meaningful once software made it an input on the cartridge side
    always_comb begin
        miscImage = miscSync; // RULE_01
        miscImage[aipb_pkg::MISC_LINK_READY_BIT] = linkReady_ff; // RULE_12
    end

    // pins already in port order: p2 on 0-7, p1 on 8-15, low = pressed
    assign playerImage = playerCtrlSync; // RULE_02 RULE_03

    // player 1 extras; unused bits read as the fill constant
    always_comb begin
        p1ExtraImage = aipb_pkg::UNUSED_FILL; // RULE_13
        p1ExtraImage[aipb_pkg::EXTRA_BTN4_BIT] = p1ExtraSync[0]; // RULE_08 RULE_03
        p1ExtraImage[aipb_pkg::EXTRA_BTN5_BIT] = p1ExtraSync[1]; // RULE_08
        p1ExtraImage[aipb_pkg::EXTRA_TEST_BIT] = p1ExtraSync[2]; // RULE_08
        p1ExtraImage[aipb_pkg::EXTRA_BTN6_BIT] = p1ExtraSync[3]; // RULE_08
    end

    // player 2 extras plus the ram layout strap (1 = old layout)
    always_comb begin
        p2ExtraImage = aipb_pkg::UNUSED_FILL; // RULE_13
        p2ExtraImage[aipb_pkg::EXTRA_BTN4_BIT] = p2ExtraSync[0]; // RULE_09 RULE_03
        p2ExtraImage[aipb_pkg::EXTRA_BTN5_BIT] = p2ExtraSync[1]; // RULE_09
        p2ExtraImage[aipb_pkg::EXTRA_BTN6_BIT] = p2ExtraSync[2]; // RULE_09
        p2ExtraImage[aipb_pkg::EXTRA_RAM_LAYOUT_BIT] = ramLayoutSync; // RULE_10 RULE_11
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [15:0] nxt_rdData;

    // pure selection: no read changes any state, so a dummy read is safe
    always_comb begin
        case (port_of(busAddr))
            SEL_MISC:   nxt_rdData = miscImage;
            SEL_PLAYER: nxt_rdData = playerImage; // RULE_04
            SEL_LINK:   nxt_rdData = linkData_ff; // RULE_05
            SEL_P1X:    nxt_rdData = p1ExtraImage;
            SEL_P2X:    nxt_rdData = p2ExtraImage;
            default:    nxt_rdData = aipb_pkg::UNMAPPED_READ; // RULE_13
        endcase
    end

    // read answer one cycle after the strobe; writes never answer
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            busRdValid <= 1'b0;
        end else begin
            busRdValid <= rdStrobe;
        end
    end

    // read data holds its last value between reads; writes are dropped
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            busRdData <= aipb_pkg::RD_DATA_RESET;
        end else if (rdStrobe) begin
            busRdData <= nxt_rdData; // RULE_13
        end
    end

    // write data carries no meaning anywhere in this bank
    logic unusedWrData;
    assign unusedWrData = ^busWrData;
endmodule

`default_nettype wire

// ===== aipb_input_port_bank_props.sv
/* aipb_input_port_bank_props: checker of the input port bank ports.
   Assumes a bind from the bench and one ref_clk domain. */
`timescale 1ns/1ps
`default_nettype none
module aipb_input_port_bank_props (
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        busCs,
    input wire logic        busRd,
    input wire logic        busWr,
    input wire logic [31:0] busAddr,
    input wire logic [15:0] busRdData,
    input wire logic        busRdValid,
    input wire logic        linkWordValid,
    input wire logic        linkWordReady,
    input wire logic        linkInputReady
);
    // ----------------
    // helpers
    // ----------------
    logic rd, wr, clr, mapped, extra;
    // decoded strobes; exact address match only, no byte lanes
    assign rd = busCs && busRd;
    assign wr = busCs && busWr;
    assign clr = wr && busAddr == aipb_pkg::ADDR_LINK_READY_CLEAR;
    assign mapped = busAddr[31:4] == 28'h1f40000 && busAddr[3:0] inside {4'h6, 4'h8, 4'ha, 4'hc, 4'he};
    assign extra = busAddr == aipb_pkg::ADDR_PLAYER1_EXTRA_INPUTS || busAddr == aipb_pkg::ADDR_PLAYER2_EXTRA_INPUTS;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // ----------------
    // properties
    // ----------------
    a_read_answered: assert property (rd |=> busRdValid)
        else $error("read got no answer");
    a_answer_cause: assert property (busRdValid |-> $past(rd))
        else $error("answer without a read");
    a_unmapped_zero: assert property (rd && !mapped |=> busRdData == 16'h0000)
        else $error("unmapped read not zero");
    a_extra_unused_zero: assert property (rd && extra |=> busRdData[7:0] == 8'h00 && busRdData[15:12] == 4'h0)
        else $error("unused extra bits not zero");
    a_misc_ready_bit: assert property (rd && busAddr == aipb_pkg::ADDR_MISC_STATUS_INPUTS |=> busRdData[4] == linkInputReady)
        else $error("misc bit 4 differs from flag");
    a_flag_holds: assert property (linkInputReady && !clr && !$past(clr) |=> linkInputReady)
        else $error("flag dropped without clear");
    a_push_sets_flag: assert property (linkWordValid && linkWordReady && !linkInputReady && !wr |-> ##[1:4] linkInputReady)
        else $error("word taken but flag not set");
    a_write_silent: assert property (wr && !rd |=> !busRdValid)
        else $error("write answered");
    a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> !busRdValid && !linkInputReady && !linkWordReady)
        else $error("outputs active after reset");
    // main scenarios reached
    c_fifo_full: cover property (linkWordValid && !linkWordReady);
    c_clear_set: cover property (clr && linkInputReady);
    c_unmapped: cover property (rd && !mapped);
endmodule
`default_nettype wire

// ===== aipb_mcu_model.sv
/* aipb_mcu_model: serial-link microcontroller seen from the port bank.
   Assumes the bench queues words in words and drives slow at negedge. */
`timescale 1ns/1ps
`default_nettype none
module aipb_mcu_model (
    input  wire logic        ref_clk,
    input  wire logic        slow,
    input  wire logic        linkWordReady,
    output logic             linkWordValid,
    output logic [15:0]      linkWord
);
    logic [15:0] words[$];
    int          taken;
    initial begin
        linkWordValid = 1'b0;
        linkWord = 16'h0000;
        taken = 0;
    end
    // offer held until taken; idle word inverted so no stale value reads as valid
    always @(posedge ref_clk) begin
        if (linkWordValid && linkWordReady) begin
            void'(words.pop_front());
            taken++;
        end
        if (linkWordValid && !linkWordReady) begin
            linkWord <= linkWord;
        end else if (words.size() != 0 && !slow) begin
            linkWordValid <= 1'b1;
            linkWord <= words[0];
        end else begin
            linkWordValid <= 1'b0;
            linkWord <= ~linkWord;
        end
    end
endmodule
`default_nettype wire

// ===== aipb_input_port_bank_tb.sv
/* aipb_input_port_bank_tb: self-checking bench of the input port bank.
   Assumes the partner model and checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module aipb_input_port_bank_tb;
    logic        ref_clk, sys_rst, busCs, busRd, busWr, busRdValid, slow;
    logic        linkWordValid, linkWordReady, linkInputReady, ramLayoutOld;
    logic [31:0] busAddr;
    logic [15:0] busWrData, busRdData, playerCtrlPins_n, miscRawPins, linkWord, rnd, d;
    logic [3:0]  p1ExtraPins_n;
    logic [2:0]  p2ExtraPins_n;
    logic [15:0] expQ[$];
    logic [31:0] addrs[6];
    int          badCount, numChecks, n;

    aipb_input_port_bank u_dut (.ref_clk, .sys_rst, .busCs, .busRd, .busWr, .busAddr, .busWrData,
        .busRdData, .busRdValid, .playerCtrlPins_n, .p1ExtraPins_n, .p2ExtraPins_n, .ramLayoutOld,
        .miscRawPins, .linkWordValid, .linkWord, .linkWordReady, .linkInputReady);
    aipb_mcu_model u_mcu (.ref_clk, .slow, .linkWordReady, .linkWordValid, .linkWord);

    // ----------------
    // helpers
    // ----------------
    function automatic logic [15:0] next_rnd(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // expected image of a port from the pins the bench drives
    function automatic logic [15:0] exp_of(input logic [31:0] a, input logic fl);
        case (a)
            aipb_pkg::ADDR_MISC_STATUS_INPUTS: return {miscRawPins[15:5], fl, miscRawPins[3:0]};
            aipb_pkg::ADDR_PLAYER_CONTROLS: return playerCtrlPins_n;
            aipb_pkg::ADDR_PLAYER1_EXTRA_INPUTS: return {4'h0, p1ExtraPins_n, 8'h00};
            aipb_pkg::ADDR_PLAYER2_EXTRA_INPUTS:
                return {4'h0, p2ExtraPins_n[2], ramLayoutOld, p2ExtraPins_n[1:0], 8'h00};
            default: return 16'h0000;
        endcase
    endfunction
    task automatic check_eq(input logic [15:0] got, input logic [15:0] exp);
        numChecks++;
        if (got !== exp) begin
            badCount++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one-cycle strobes launched at negedge, answer sampled a cycle later
    task automatic bus_rd(input logic [31:0] a, output logic [15:0] q);
        busCs = 1'b1;
        busRd = 1'b1;
        busAddr = a;
        @(negedge ref_clk);
        busCs = 1'b0;
        busRd = 1'b0;
        check_eq({15'h0000, busRdValid}, 16'h0001);
        q = busRdData;
        @(negedge ref_clk);
    endtask
    task automatic bus_wr(input logic [31:0] a, input logic [15:0] v);
        busCs = 1'b1;
        busWr = 1'b1;
        busAddr = a;
        busWrData = v;
        @(negedge ref_clk);
        busCs = 1'b0;
        busWr = 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ----------------
    // stimulus
    // ----------------
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // hang guard, well above the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge ref_clk);
        badCount++;
        report_and_stop();
    end
    initial begin
        {busCs, busRd, busWr, slow, ramLayoutOld} = '0;
        busAddr = '0;
        busWrData = '0;
        playerCtrlPins_n = '1;
        miscRawPins = '0;
        p1ExtraPins_n = '1;
        p2ExtraPins_n = '1;
        badCount = 0;
        numChecks = 0;
        rnd = 16'h000b;
        addrs = '{aipb_pkg::ADDR_MISC_STATUS_INPUTS, aipb_pkg::ADDR_PLAYER_CONTROLS,
            aipb_pkg::ADDR_PLAYER1_EXTRA_INPUTS, aipb_pkg::ADDR_PLAYER2_EXTRA_INPUTS, 32'h1f400010, 32'h1f400007};
        sys_rst = 1'b1;
        repeat (6) @(negedge ref_clk);
        sys_rst = 1'b0;
        // pins all pressed, all released, then random; writes must not stick
        for (int i = 0; i < 12; i++) begin
            rnd = next_rnd(rnd);
            d = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : rnd;
            playerCtrlPins_n = d;
            miscRawPins = ~d;
            p1ExtraPins_n = d[3:0];
            p2ExtraPins_n = d[6:4];
            ramLayoutOld = d[7];
            repeat (3) @(negedge ref_clk);
            foreach (addrs[k]) begin
                bus_wr(addrs[k], rnd);
                bus_rd(addrs[k], d);
                check_eq(d, exp_of(addrs[k], 1'b0));
            end
            bus_rd(aipb_pkg::ADDR_PLAYER_CONTROLS, d);
            check_eq(d, playerCtrlPins_n);
        end
        $display("test ports done");
        // six words queued: one in the port, four in the fifo, one refused
        for (int i = 0; i < 6; i++) begin
            rnd = next_rnd(rnd);
            expQ.push_back(rnd);
            u_mcu.words.push_back(rnd);
        end
        n = 0;
        while ((linkWordReady !== 1'b0 || u_mcu.taken < 5) && n < 60) begin
            rnd = next_rnd(rnd);
            slow = rnd[0];
            @(negedge ref_clk);
            n++;
        end
        repeat (4) @(negedge ref_clk);
        check_eq(16'(u_mcu.taken), 16'h0005);
        check_eq({15'h0000, linkWordReady}, 16'h0000);
        // drain all six words; the partner holds its last word once offered, but slow can delay that offer
        for (int i = 0; i < 6; i++) begin
            n = 0;
            while (linkInputReady !== 1'b1 && n < 40) begin
                rnd = next_rnd(rnd);
                slow = rnd[0];
                @(negedge ref_clk);
                n++;
            end
            bus_rd(aipb_pkg::ADDR_PLAYER_CONTROLS, d);
            bus_rd(aipb_pkg::ADDR_LINK_DATA_WORD, d);
            check_eq(d, expQ.pop_front());
            bus_rd(aipb_pkg::ADDR_MISC_STATUS_INPUTS, d);
            check_eq({15'h0000, d[4]}, 16'h0001);
            bus_wr(aipb_pkg::ADDR_LINK_READY_CLEAR, rnd);
        end
        repeat (3) @(negedge ref_clk);
        check_eq({15'h0000, linkInputReady}, 16'h0000);
        bus_rd(aipb_pkg::ADDR_MISC_STATUS_INPUTS, d);
        check_eq(d, exp_of(aipb_pkg::ADDR_MISC_STATUS_INPUTS, 1'b0));
        $display("test link done");
        report_and_stop();
    end
endmodule

bind aipb_input_port_bank aipb_input_port_bank_props u_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .busCs(busCs), .busRd(busRd), .busWr(busWr), .busAddr(busAddr), .busRdData(busRdData),
    .busRdValid(busRdValid), .linkWordValid(linkWordValid), .linkWordReady(linkWordReady),
    .linkInputReady(linkInputReady));
`default_nettype wire
